/* File: logic/otc_defines.svh */
`ifndef OTC_DEFINES_SVH
`define OTC_DEFINES_SVH

// register offsets
`define OTC_ADDR_ITRIM 8'h0b
`define OTC_ADDR_CURV 8'h0c
`define OTC_ADDR_CTRL 8'h0d

// control register field positions
`define OTC_COMP_EN_BIT 7
`define OTC_BAT_COMP_EN_BIT 6
`define OTC_BAT_COMP_RATE_BIT 5
`define OTC_CURV_MASK 8'h7f
`define OTC_CTRL_MASK 8'hef

// reset values
`define OTC_ITRIM_RST 8'h00
`define OTC_CURV_RST 7'h00
`define OTC_GAIN_RST 4'h8
`define OTC_PPM_RST 7'sh20

// step gain limits
`define OTC_GAIN_MIN 4'h4
`define OTC_GAIN_MAX 4'hc

// trim arithmetic
`define OTC_ANALOG_ZERO 17'sh0_0020
`define OTC_ANALOG_LOW -17'sh0_001f
`define OTC_T_REF_C 9'sh019

// timing: times in their own unit, counts derived from the clock rate
`define OTC_CLK_HZ 64'h0000_0000_02fa_f080
`define OTC_T_BAT_SLOW_MIN 64'h0000_0000_0000_000a
`define OTC_T_BAT_FAST_MIN 64'h0000_0000_0000_0001
`define OTC_T_VDD_MS 64'h0000_0000_0000_03e8
`define OTC_BAT_SLOW_CYC (`OTC_T_BAT_SLOW_MIN * 64'd60 * `OTC_CLK_HZ)
`define OTC_BAT_FAST_CYC (`OTC_T_BAT_FAST_MIN * 64'd60 * `OTC_CLK_HZ)
`define OTC_VDD_CYC (`OTC_T_VDD_MS * `OTC_CLK_HZ / 64'd1000)

`endif

/* File: logic/otc_pkg.sv */
package otc_pkg;

  typedef enum logic [1:0] {
    OTC_IDLE,
    OTC_CONV,
    OTC_CALC
  } otc_state_e;

  typedef struct packed {
    logic [7:0] itrim;
    logic [6:0] curv;
    logic comp_en;
    logic bat_comp_en;
    logic bat_comp_rate;
    logic [3:0] gain;
    logic [1:0] bat_sync;
    logic [1:0] low_sync;
    logic comp_en_prev;
    logic [35:0] tick_cnt;
    otc_state_e st;
    logic adc_start;
    logic calc_req;
    logic signed [7:0] temp;
    logic [5:0] analog_trim;
    logic [2:0] dtr;
    logic signed [6:0] ppm;
    logic [7:0] rdata;
  } otc_main_s;

  typedef struct packed {
    logic done;
    logic [5:0] fatr;
    logic [2:0] fdtr;
  } otc_calc_s;

endpackage

/* File: logic/otc_calc_if.sv */
`timescale 1ns/1ps
interface otc_calc_if;
  logic req;
  logic signed [7:0] temp;
  logic [6:0] curv;
  logic [3:0] gain;
  logic [7:0] itrim;
  logic done;
  logic [5:0] fatr;
  logic [2:0] fdtr;

  modport ctrl (output req, temp, curv, gain, itrim, input done, fatr, fdtr);
  modport calc (input req, temp, curv, gain, itrim, output done, fatr, fdtr);
endinterface

/* File: logic/otc_trim_calc.sv */
`timescale 1ns/1ps
`include "otc_defines.svh"
module otc_trim_calc import otc_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  otc_calc_if.calc c
);

  otc_calc_s q, n;
  logic signed [8:0] dev;
  logic signed [17:0] sq;
  logic [23:0] prod;
  logic [3:0] g;
  logic [17:0] scaled;
  logic signed [16:0] a;
  logic signed [16:0] ds;
  logic signed [16:0] dsum;
  logic signed [3:0] d0;

  // final trims from temperature, curvature, gain and initial trims
  always_comb begin
    n = q;
    dev = {c.temp[7], c.temp} - `OTC_T_REF_C;
    sq = dev * dev;
    prod = 24'(sq[16:0]) * 24'(c.curv);
    // gain held inside its legal span
    if (c.gain < `OTC_GAIN_MIN) begin
      g = `OTC_GAIN_MIN;
    end else if (c.gain > `OTC_GAIN_MAX) begin
      g = `OTC_GAIN_MAX;
    end else begin
      g = c.gain;
    end
    // ppm correction scaled to analog codes, eighths of a step
    scaled = 18'(prod[23:10]) * 18'(g);
    a = `OTC_ANALOG_ZERO - 17'(c.itrim[5:0]) + 17'(scaled[17:3]);
    case (c.itrim[7:6])
      2'b01: d0 = 4'sd1;
      2'b11: d0 = -4'sd1;
      default: d0 = 4'sd0;
    endcase
    // overflow of the analog span moves to 32 ppm digital steps
    ds = (a > `OTC_ANALOG_ZERO) ? ((a - 17'sd1) >>> 5) : 17'sd0;
    a = a - (ds <<< 5);
    dsum = 17'(d0) + ds;
    if (dsum > 17'sd6) begin
      dsum = 17'sd6;
    end
    if (a < `OTC_ANALOG_LOW) begin
      a = `OTC_ANALOG_LOW;
    end
    n.done = c.req;
    if (c.req) begin
      n.fatr = 6'(`OTC_ANALOG_ZERO - a);
      n.fdtr = dsum[2:0];
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign c.done = q.done;
  assign c.fatr = q.fatr;
  assign c.fdtr = q.fdtr;

  chk_calc_done: assert property (@(posedge clk) disable iff (!arst_n)
    c.req |=> c.done) else $error("calc result not ready one cycle after request");
  chk_calc_reftemp: assert property (@(posedge clk) disable iff (!arst_n)
    (c.req && c.temp == 8'sd25) |=> (c.fatr == $past(c.itrim[5:0])))
    else $error("zero curvature term changed the analog trim");

endmodule // otc_trim_calc

/* File: logic/otc_comp_ctrl.sv */
`timescale 1ns/1ps
`include "otc_defines.svh"
module otc_comp_ctrl import otc_pkg::*; #(
  parameter logic [35:0] BAT_SLOW_CYC = 36'(`OTC_BAT_SLOW_CYC),
  parameter logic [35:0] BAT_FAST_CYC = 36'(`OTC_BAT_FAST_CYC),
  parameter logic [35:0] VDD_CYC = 36'(`OTC_VDD_CYC)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic battery_mode,
  input wire logic vbat_low,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic signed [7:0] adc_temp,
  output logic [5:0] analog_trim,
  output logic [2:0] digital_trim,
  output logic signed [6:0] analog_ppm,
  output logic comp_busy
);

  otc_main_s q, n;
  otc_calc_if u_if ();
  logic on_bat;
  logic bat_low;
  logic allowed;
  logic fire;
  logic [35:0] period;

  otc_trim_calc u_calc (
    .clk(clk),
    .arst_n(arst_n),
    .c(u_if.calc)
  );

  // register select, shared by write and read paths
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    case (addr)
      `OTC_ADDR_ITRIM: reg_sel = 2'h1;
      `OTC_ADDR_CURV: reg_sel = 2'h2;
      `OTC_ADDR_CTRL: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction

  // offset in ppm of an analog code
  function automatic logic signed [6:0] ppm_of(input logic [5:0] code);
    ppm_of = 7'sd32 - $signed({1'b0, code});
  endfunction

  // initial digital trim mapped onto the final digital code
  function automatic logic [2:0] dtr_of(input logic [1:0] idt);
    case (idt)
      2'b01: dtr_of = 3'h1;
      2'b11: dtr_of = 3'h7;
      default: dtr_of = 3'h0;
    endcase
  endfunction

  // synchronised monitors and the sensing tick
  assign on_bat = q.bat_sync[1];
  assign bat_low = q.low_sync[1];
  assign allowed = q.comp_en && (!on_bat || (q.bat_comp_en && !bat_low));
  assign period = on_bat ? (q.bat_comp_rate ? BAT_FAST_CYC : BAT_SLOW_CYC) : VDD_CYC;
  assign fire = allowed && ((q.tick_cnt >= period - 36'h1) || !q.comp_en_prev);

  // next-state logic
  always_comb begin
    n = q;
    n.adc_start = 1'b0;
    n.calc_req = 1'b0;
    n.bat_sync = {q.bat_sync[0], battery_mode};
    n.low_sync = {q.low_sync[0], vbat_low};
    n.comp_en_prev = q.comp_en;
    // register writes
    if (reg_wr) begin
      case (reg_sel(reg_addr))
        2'h1: n.itrim = reg_wdata;
        2'h2: n.curv = reg_wdata[6:0];
        2'h3: begin
          n.comp_en = reg_wdata[`OTC_COMP_EN_BIT];
          n.bat_comp_en = reg_wdata[`OTC_BAT_COMP_EN_BIT];
          n.bat_comp_rate = reg_wdata[`OTC_BAT_COMP_RATE_BIT];
          n.gain = reg_wdata[3:0];
        end
        default: ;
      endcase
    end
    // read data, unmapped offsets read zero
    case (reg_sel(reg_addr))
      2'h1: n.rdata = q.itrim;
      2'h2: n.rdata = {1'b0, q.curv};
      2'h3: n.rdata = {q.comp_en, q.bat_comp_en, q.bat_comp_rate, 1'b0, q.gain};
      default: n.rdata = 8'h00;
    endcase
    // interval counter
    if (!allowed || fire) begin
      n.tick_cnt = 36'h0;
    end else begin
      n.tick_cnt = q.tick_cnt + 36'h1;
    end
    // sensing sequence
    case (q.st)
      OTC_IDLE: begin
        if (fire) begin
          n.adc_start = 1'b1;
          n.st = OTC_CONV;
        end
      end
      OTC_CONV: begin
        if (!q.comp_en) begin
          n.st = OTC_IDLE;
        end else if (adc_done) begin
          n.temp = adc_temp;
          n.calc_req = 1'b1;
          n.st = OTC_CALC;
        end
      end
      OTC_CALC: begin
        if (u_if.done) begin
          if (q.comp_en) begin
            n.analog_trim = u_if.fatr;
            n.dtr = u_if.fdtr;
            n.ppm = ppm_of(u_if.fatr);
          end
          n.st = OTC_IDLE;
        end
      end
      default: n.st = OTC_IDLE;
    endcase
    // compensation off: trims come straight from the initial register
    if (!q.comp_en) begin
      n.analog_trim = q.itrim[5:0];
      n.dtr = dtr_of(q.itrim[7:6]);
      n.ppm = ppm_of(q.itrim[5:0]);
      n.st = OTC_IDLE;
    end
  end

  // state register; enable bits clear at reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.itrim <= `OTC_ITRIM_RST;
      q.curv <= `OTC_CURV_RST;
      q.gain <= `OTC_GAIN_RST;
      q.ppm <= `OTC_PPM_RST; // code 0 means +32 ppm, even in reset
    end else begin
      q <= n;
    end
  end

  // outputs and calculator hookup
  assign u_if.req = q.calc_req;
  assign u_if.temp = q.temp;
  assign u_if.curv = q.curv;
  assign u_if.gain = q.gain;
  assign u_if.itrim = q.itrim;
  assign reg_rdata = q.rdata;
  assign adc_start = q.adc_start;
  assign analog_trim = q.analog_trim;
  assign digital_trim = q.dtr;
  assign analog_ppm = q.ppm;
  assign comp_busy = (q.st != OTC_IDLE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_fire_idle;
    (q.st == OTC_IDLE) && fire;
  endsequence

  sequence s_conv_start;
    adc_start && (q.st == OTC_CONV);
  endsequence

  sequence s_result;
    (q.st == OTC_CALC) && u_if.done && q.comp_en;
  endsequence

  chk_itrim_write: assert property ((reg_wr && reg_addr == `OTC_ADDR_ITRIM)
    |=> (q.itrim == $past(reg_wdata))) else $error("initial trim not stored");
  chk_curv_msb: assert property ((reg_addr == `OTC_ADDR_CURV)
    |=> (reg_rdata[7] == 1'b0)) else $error("curvature bit 7 not zero");
  chk_ctrl_layout: assert property ((reg_addr == `OTC_ADDR_CTRL)
    |=> (reg_rdata[4] == 1'b0 && reg_rdata[7] == $past(q.comp_en)
    && reg_rdata[3:0] == $past(q.gain))) else $error("control read layout wrong");
  chk_direct_trim: assert property (!q.comp_en |=> (analog_trim == $past(q.itrim[5:0])
    && digital_trim == dtr_of($past(q.itrim[7:6])))) else $error("direct trim lost");
  chk_bat_inhibit: assert property ((on_bat && bat_low) |-> !fire)
    else $error("sensing on low battery");
  chk_bat_disabled: assert property ((on_bat && !q.bat_comp_en) |-> !fire)
    else $error("sensing on battery while disabled");
  chk_seq_start: assert property (s_fire_idle |=> s_conv_start ##1 !adc_start)
    else $error("sensing cycle did not start");
  chk_result_apply: assert property (s_result |=> (analog_trim == $past(u_if.fatr)
    && digital_trim == $past(u_if.fdtr))) else $error("final trim not applied");
  chk_ppm_map: assert property (analog_ppm == ppm_of(analog_trim))
    else $error("ppm offset does not match code");
  chk_rate_fast: assert property ((on_bat && q.bat_comp_rate) |-> (period == BAT_FAST_CYC))
    else $error("battery rate select wrong");

endmodule // otc_comp_ctrl

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic battery_mode = 1'b0;
  logic vbat_low = 1'b0;
  logic adc_done = 1'b0;
  logic signed [7:0] adc_temp = 8'sh19;
  logic [7:0] reg_rdata;
  logic adc_start;
  logic [5:0] analog_trim;
  logic [2:0] digital_trim;
  logic signed [6:0] analog_ppm;
  logic comp_busy;
  logic [2:0] pend = 3'h0;
  logic [7:0] rd;
  logic ok;
  int errors = 0;
  int n_checks = 0;
  int n_start = 0;
  int cyc = 0;
  int last_start = 0;

  // block under test, sensing intervals shortened to 40, 10 and 20 cycles
  otc_comp_ctrl #(
    .BAT_SLOW_CYC(36'h0_0000_0028),
    .BAT_FAST_CYC(36'h0_0000_000a),
    .VDD_CYC(36'h0_0000_0014)
  ) DUT (
    .clk(clk),
    .arst_n(arst_n),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .battery_mode(battery_mode),
    .vbat_low(vbat_low),
    .adc_start(adc_start),
    .adc_done(adc_done),
    .adc_temp(adc_temp),
    .analog_trim(analog_trim),
    .digital_trim(digital_trim),
    .analog_ppm(analog_ppm),
    .comp_busy(comp_busy)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // converter stand-in: answers each start four cycles later
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pend <= {pend[1:0], adc_start === 1'b1};
    adc_done <= pend[2];
    if (adc_start === 1'b1) begin
      n_start <= n_start + 1;
      last_start <= cyc;
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = reg_rdata;
  endtask

  // waits a bounded time for the next conversion start
  task automatic wait_start(input int lim, output logic seen);
    int n0;
    n0 = n_start;
    for (int i = 0; i < lim && n_start == n0; i++) begin
      @(posedge clk);
      #1;
    end
    seen = (n_start != n0);
  endtask

  task automatic t_reset;
    rdr(8'h0d, rd);
    chk("ctrl", rd, 8'h08);
    rdr(8'h0b, rd);
    chk("itrim", rd, 8'h00);
    chk("analog_trim", {2'b00, analog_trim}, 8'h00);
    chk("ppm", {analog_ppm[6], analog_ppm}, 8'h20);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(8'h0b, 8'hff);
    rdr(8'h0b, rd);
    chk("itrim", rd, 8'hff);
    wr(8'h0c, 8'hff);
    rdr(8'h0c, rd);
    chk("curv", rd, 8'h7f);
    wr(8'h0d, 8'h7c);
    rdr(8'h0d, rd);
    chk("ctrl", rd, 8'h6c);
    wr(8'h0e, 8'h55);
    rdr(8'h0e, rd);
    chk("unmapped", rd, 8'h00);
    wr(8'h0d, 8'h08);
    $display("test regs done");
  endtask

  task automatic t_static;
    logic [7:0] c [4] = '{8'h00, 8'h5f, 8'hbf, 8'he0};
    logic [7:0] dx [4] = '{8'h00, 8'h01, 8'h00, 8'h07};
    for (int i = 0; i < 4; i++) begin
      wr(8'h0b, c[i]);
      repeat (2) @(posedge clk);
      #1;
      chk("analog_trim", {2'b00, analog_trim}, {2'b00, c[i][5:0]});
      chk("ppm", {analog_ppm[6], analog_ppm}, 8'(32 - int'(c[i][5:0])));
      chk("digital_trim", {5'h00, digital_trim}, dx[i]);
    end
    chk("starts", 8'(n_start), 8'h00);
    $display("test static done");
  endtask

  // waits a bounded time for the sensing cycle to end, then two cycles more
  task automatic wait_idle;
    for (int i = 0; i < 20 && comp_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_enable;
    int n0;
    wr(8'h0c, 8'h23);
    wr(8'h0b, 8'h4a);
    wr(8'h0d, 8'h08);
    wr(8'h0d, 8'h88);
    wait_start(20, ok);
    chk("start", {7'h00, ok}, 8'h01);
    chk("busy", {7'h00, comp_busy}, 8'h01);
    wait_idle;
    chk("busy", {7'h00, comp_busy}, 8'h00);
    chk("analog_trim", {2'b00, analog_trim}, 8'h0a);
    chk("digital_trim", {5'h00, digital_trim}, 8'h01);
    chk("ppm", {analog_ppm[6], analog_ppm}, 8'h16);
    // cold reading: 30 ppm correction, one 32 ppm step carried to digital
    @(posedge clk);
    adc_temp <= 8'shfb;
    wait_start(40, ok);
    chk("restart", {7'h00, ok}, 8'h01);
    wait_idle;
    chk("analog_trim cold", {2'b00, analog_trim}, 8'h0c);
    chk("digital_trim cold", {5'h00, digital_trim}, 8'h02);
    chk("ppm cold", {analog_ppm[6], analog_ppm}, 8'h14);
    wr(8'h0d, 8'h08);
    adc_temp <= 8'sh19;
    repeat (10) @(posedge clk);
    n0 = n_start;
    repeat (60) @(posedge clk);
    chk("starts off", 8'(n_start - n0), 8'h00);
    $display("test enable done");
  endtask

  task automatic t_battery;
    int n0;
    int g;
    battery_mode <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h0d, 8'h88);
    n0 = n_start;
    repeat (100) @(posedge clk);
    chk("starts no bat", 8'(n_start - n0), 8'h00);
    wr(8'h0d, 8'ha8);
    n0 = n_start;
    repeat (60) @(posedge clk);
    chk("starts no bat fast", 8'(n_start - n0), 8'h00);
    wr(8'h0d, 8'he8);
    wait_start(60, ok);
    wait_start(30, ok);
    g = last_start;
    wait_start(30, ok);
    chk("fast gap", {7'h00, ok && last_start - g inside {[8:20]}}, 8'h01);
    wr(8'h0d, 8'hc8);
    wait_start(60, ok);
    g = last_start;
    wait_start(70, ok);
    chk("slow gap", {7'h00, ok && last_start - g inside {[38:60]}}, 8'h01);
    vbat_low <= 1'b1;
    repeat (12) @(posedge clk);
    n0 = n_start;
    repeat (150) @(posedge clk);
    chk("starts low", 8'(n_start - n0), 8'h00);
    vbat_low <= 1'b0;
    battery_mode <= 1'b0;
    wr(8'h0d, 8'h08);
    $display("test battery done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_static;
    t_enable;
    t_battery;
    give_verdict;
  end

  // watchdog well beyond the expected run
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule // tb
